// ==== hdl/rc_adc_pkg.sv ====
// Purpose: Shared constants and lookups for the dual-counter RC converter block.
// Assumes: Byte-wide registers, one per 32-bit Wishbone word, index times four.
// Operation
// - Converter bit one picks timer or converter
// - Two independent sixteen-bit up counters
// - Reference clock from system, divide-four, rtc
// - Mode codes 000, 001, 010 pick sources
// - Measurement counts converter clock, reference internal
// - Bits seven-four pick the measurement source
// - Bit zero picks which overflow flags
// - Overflow select ignored in timer function
// - Run bit starts both counters in converter function, reference alone in timer
// - Converter overflow stops, clears run; timer overflow reloads, sets flag
// - Low write buffers, high write loads
// - High read latches low; low reads buffer
// - Counter registers refused while running
// - Converter bits three-two read zero
package rc_adc_pkg;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1);

    // Register indices; byte address is index times four
    localparam logic [5:0] IDX_REF_LOW = 6'h20;
    localparam logic [5:0] IDX_REF_HIGH = 6'h21;
    localparam logic [5:0] IDX_TIMER_CTRL = 6'h22;
    localparam logic [5:0] IDX_MEAS_LOW = 6'h23;
    localparam logic [5:0] IDX_MEAS_HIGH = 6'h24;
    localparam logic [5:0] IDX_CONV_CTRL = 6'h25;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h26;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h27;

    // Field positions
    localparam int CONV_OVF_SEL_BIT = 0;
    localparam int CONV_SELECT_BIT = 1;
    localparam int CONV_MODE_LSB = 4;
    localparam int TCTL_RUN_BIT = 4;
    localparam int TCTL_MODE_LSB = 5;
    localparam int IRQ_TIMER_BIT = 4;
    localparam logic [7:0] CONV_CTRL_WMASK = 8'hf3;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h10;

    // Reset values
    localparam logic [7:0] CONV_CTRL_RST = 8'h00;
    localparam logic [7:0] TCTL_RST = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;

    // Reference clock modes
    localparam logic [2:0] REF_SYS = 3'h0;
    localparam logic [2:0] REF_DIV4 = 3'h1;
    localparam logic [2:0] REF_RTC = 3'h2;

    // Measurement modes
    localparam logic [3:0] MEAS_EXT_A = 4'h0;
    localparam logic [3:0] MEAS_RS_CS_A = 4'h1;
    localparam logic [3:0] MEAS_RT_CS_A = 4'h2;
    localparam logic [3:0] MEAS_CRT_CS_A = 4'h3;
    localparam logic [3:0] MEAS_RS_CRT_A = 4'h4;
    localparam logic [3:0] MEAS_RS_CS_B = 4'h5;
    localparam logic [3:0] MEAS_RT_CS_B = 4'h6;
    localparam logic [3:0] MEAS_EXT_B = 4'h7;

    // Analog switch lookups; bit 0 is the first switch of each group
    function automatic logic [2:0] ref_switches(input logic [2:0] mode);
        unique case (mode)
            REF_SYS: ref_switches = 3'h1;
            REF_DIV4: ref_switches = 3'h2;
            REF_RTC: ref_switches = 3'h4;
            default: ref_switches = 3'h0;
        endcase
    endfunction

    function automatic logic [9:0] meas_switches(input logic [3:0] mode);
        unique case (mode)
            MEAS_EXT_A: meas_switches = 10'h100;
            MEAS_RS_CS_A: meas_switches = 10'h109;
            MEAS_RT_CS_A: meas_switches = 10'h111;
            MEAS_CRT_CS_A: meas_switches = 10'h105;
            MEAS_RS_CRT_A: meas_switches = 10'h10a;
            MEAS_RS_CS_B: meas_switches = 10'h260;
            MEAS_RT_CS_B: meas_switches = 10'h2a0;
            MEAS_EXT_B: meas_switches = 10'h200;
            default: meas_switches = 10'h000;
        endcase
    endfunction
endpackage

// ==== hdl/edge_sync.sv ====
// Purpose: Bring an external clock into the system domain, flag rising edges.
// Assumes: Input toggles well below half the system clock rate.
// Notes: Rise pulse lags the pin by about two cycles.
`timescale 1ns/1ps
module edge_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Two-stage synchroniser, then one stage for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;

    a_rise_single: assert property (@(posedge clk) disable iff (!rst_n)
        rise |=> !rise) else $error("edge pulse longer than one cycle");
endmodule

// ==== hdl/up_counter.sv ====
// Purpose: Loadable up counter with overflow and wrap value.
// Assumes: Load has priority over counting.
// Notes: Overflow is a pulse in the cycle the count passes all ones.
`timescale 1ns/1ps
module up_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    input wire logic inc,
    input wire logic [WIDTH-1:0] wrap_val,
    output logic [WIDTH-1:0] count_q,
    output logic ovf
);
    assign ovf = inc & (&count_q);

    // Count, wrap on overflow, or take a full parallel load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_val;
        end else if (ovf) begin
            count_q <= wrap_val;
        end else if (inc) begin
            count_q <= count_q + 1'b1;
        end
    end

    a_wrap_on_ovf: assert property (@(posedge clk) disable iff (!rst_n)
        ovf && !load |=> count_q == $past(wrap_val))
        else $error("counter did not wrap on overflow");
endmodule

// ==== hdl/rc_adc_dual_counter.sv ====
// Purpose: RC converter control with reference and measurement counters.
// Assumes: Classic Wishbone slave, byte registers in data bits 7:0.
// Notes: Every access is acknowledged; refused ones read zero, write nothing.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module rc_adc_dual_counter #(
    parameter int ADR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rtc_tick,
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    input wire logic osc_a_in,
    input wire logic osc_b_in,
    output logic [2:0] ref_switch_en,
    output logic [9:0] meas_switch_en,
    output logic irq
);
    import rc_adc_pkg::*;

    logic [7:0] conv_ctrl_q;
    logic [7:0] tctl_q;
    logic [7:0] irq_status_q;
    logic [7:0] irq_mask_q;
    logic [7:0] ref_buf_q;
    logic [7:0] meas_buf_q;
    logic [7:0] rd_data_d;
    logic [7:0] clr_bits;
    logic [31:0] dat_q;
    logic ack_q;
    logic [1:0] div_q;
    logic rtc_q;
    logic [2:0] ref_sw_q;
    logic [9:0] meas_sw_q;
    logic ref_tick;
    logic meas_src;
    logic meas_rise;
    logic [CNT_W-1:0] ref_count;
    logic [CNT_W-1:0] meas_count;
    logic [CNT_W-1:0] ref_wrap;
    logic ref_ovf;
    logic meas_ovf;

    // Bus decode; side effects happen only at the acknowledge edge
    logic req;
    logic acc;
    logic wr;
    logic rd;
    logic [5:0] idx;
    logic run;
    logic conv;
    logic cnt_reg;
    logic locked;
    logic [2:0] ref_mode;
    logic [3:0] meas_mode;
    assign req = wb_cyc_i & wb_stb_i;
    assign acc = req & ack_q;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign rd = acc & ~wb_we_i;
    assign idx = wb_adr_i[7:2];
    assign run = tctl_q[TCTL_RUN_BIT];
    assign conv = conv_ctrl_q[CONV_SELECT_BIT];
    assign ref_mode = tctl_q[TCTL_MODE_LSB +: 3];
    assign meas_mode = conv_ctrl_q[CONV_MODE_LSB +: 4];
    assign cnt_reg = (idx == IDX_REF_LOW) || (idx == IDX_REF_HIGH) ||
                     (idx == IDX_MEAS_LOW) || (idx == IDX_MEAS_HIGH);
    assign locked = run & cnt_reg;

    // Free-running divider gives the instruction clock enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    // Prescaler output arrives synchronous; only its rising edge counts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rtc_q <= 1'b0;
        end else begin
            rtc_q <= rtc_tick;
        end
    end

    // Reference clock enable; unlisted modes leave the counter idle
    always_comb begin
        ref_tick = 1'b0;
        unique case (ref_mode)
            REF_SYS: ref_tick = 1'b1;
            REF_DIV4: ref_tick = (div_q == DIV_LAST);
            REF_RTC: ref_tick = rtc_tick & ~rtc_q;
            default: ref_tick = 1'b0;
        endcase
    end

    // Measurement source; changing mode mid-run can inject one false edge
    always_comb begin
        meas_src = 1'b0;
        unique case (meas_mode)
            MEAS_EXT_A: meas_src = ext_clock_in_a;
            MEAS_RS_CS_A, MEAS_RT_CS_A, MEAS_CRT_CS_A, MEAS_RS_CRT_A: meas_src = osc_a_in;
            MEAS_RS_CS_B, MEAS_RT_CS_B: meas_src = osc_b_in;
            MEAS_EXT_B: meas_src = ext_clock_in_b;
            default: meas_src = 1'b0;
        endcase
    end

    edge_sync u_meas_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(meas_src),
        .rise(meas_rise)
    );

    // Counter controls; the two counters never share a clock source
    logic ref_inc;
    logic meas_inc;
    logic ref_load;
    logic meas_load;
    logic conv_stop;
    logic flag_set;
    assign ref_inc = run & ref_tick;
    assign meas_inc = run & conv & meas_rise;
    assign ref_load = wr & ~run & (idx == IDX_REF_HIGH);
    assign meas_load = wr & ~run & (idx == IDX_MEAS_HIGH);
    // Timer function reloads from the measurement word used as preload
    assign ref_wrap = conv ? CNT_RST : meas_count;
    assign conv_stop = conv & (ref_ovf | meas_ovf);
    // Overflow select only matters in converter function
    assign flag_set = conv ? (conv_ctrl_q[CONV_OVF_SEL_BIT] ? meas_ovf : ref_ovf)
                           : ref_ovf;

    up_counter #(.WIDTH(CNT_W)) u_ref_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .load(ref_load),
        .load_val({wb_dat_i[7:0], ref_buf_q}),
        .inc(ref_inc),
        .wrap_val(ref_wrap),
        .count_q(ref_count),
        .ovf(ref_ovf)
    );

    up_counter #(.WIDTH(CNT_W)) u_meas_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .load(meas_load),
        .load_val({wb_dat_i[7:0], meas_buf_q}),
        .inc(meas_inc),
        .wrap_val(CNT_RST),
        .count_q(meas_count),
        .ovf(meas_ovf)
    );

    // Low byte buffers: written by software, or latched by a high read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_buf_q <= 8'h00;
            meas_buf_q <= 8'h00;
        end else if (acc && !locked) begin
            if (wr && idx == IDX_REF_LOW) begin
                ref_buf_q <= wb_dat_i[7:0];
            end
            if (rd && idx == IDX_REF_HIGH) begin
                ref_buf_q <= ref_count[7:0];
            end
            if (wr && idx == IDX_MEAS_LOW) begin
                meas_buf_q <= wb_dat_i[7:0];
            end
            if (rd && idx == IDX_MEAS_HIGH) begin
                meas_buf_q <= meas_count[7:0];
            end
        end
    end

    // Timer control; an overflow stop beats a same-cycle write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tctl_q <= TCTL_RST;
        end else begin
            if (wr && idx == IDX_TIMER_CTRL) begin
                tctl_q <= wb_dat_i[7:0];
            end
            if (conv_stop) begin
                tctl_q[TCTL_RUN_BIT] <= 1'b0;
            end
        end
    end

    // Converter control; bits 3:2 are not stored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_ctrl_q <= CONV_CTRL_RST;
        end else if (wr && idx == IDX_CONV_CTRL) begin
            conv_ctrl_q <= wb_dat_i[7:0] & CONV_CTRL_WMASK;
        end
    end

    // Sticky flag, write one to clear; a new overflow beats the clear
    assign clr_bits = (wr && idx == IDX_IRQ_STATUS) ? wb_dat_i[7:0] : 8'h00;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_status_q <= IRQ_STATUS_RST;
        end else begin
            irq_status_q <= ((irq_status_q & ~clr_bits) |
                             ({7'h00, flag_set} << IRQ_TIMER_BIT)) & IRQ_IMPL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_mask_q <= IRQ_MASK_RST;
        end else if (wr && idx == IDX_IRQ_MASK) begin
            irq_mask_q <= wb_dat_i[7:0] & IRQ_IMPL_MASK;
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // Read mux; a locked counter register reads as zero
    always_comb begin
        rd_data_d = 8'h00;
        unique case (idx)
            IDX_REF_LOW: rd_data_d = ref_buf_q;
            IDX_REF_HIGH: rd_data_d = ref_count[15:8];
            IDX_TIMER_CTRL: rd_data_d = tctl_q;
            IDX_MEAS_LOW: rd_data_d = meas_buf_q;
            IDX_MEAS_HIGH: rd_data_d = meas_count[15:8];
            IDX_CONV_CTRL: rd_data_d = conv_ctrl_q;
            IDX_IRQ_STATUS: rd_data_d = irq_status_q;
            IDX_IRQ_MASK: rd_data_d = irq_mask_q;
            default: rd_data_d = 8'h00;
        endcase
        if (locked) begin
            rd_data_d = 8'h00;
        end
    end

    // One-wait-state acknowledge with registered read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (req && !ack_q) begin
            ack_q <= 1'b1;
            dat_q <= {24'h00_0000, rd_data_d};
        end else begin
            ack_q <= 1'b0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Analog switches are released outside converter function
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_sw_q <= 3'h0;
            meas_sw_q <= 10'h000;
        end else begin
            ref_sw_q <= conv ? ref_switches(ref_mode) : 3'h0;
            meas_sw_q <= conv ? meas_switches(meas_mode) : 10'h000;
        end
    end

    assign ref_switch_en = ref_sw_q;
    assign meas_switch_en = meas_sw_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence div_gap;
        !(div_q == DIV_LAST) [*3] ##1 (div_q == DIV_LAST);
    endsequence

    sequence sel_ovf;
        conv && (conv_ctrl_q[CONV_OVF_SEL_BIT] ? meas_ovf : ref_ovf);
    endsequence

    // Run falls first, then neither counter may move
    sequence stop_hold;
        !run ##1 ($stable(ref_count) && $stable(meas_count));
    endsequence

    // Answer one cycle after the request, gone again the cycle after
    sequence ack_then_idle;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_flag_on_ovf: assert property (sel_ovf |=> irq_status_q[IRQ_TIMER_BIT])
        else $error("selected overflow did not set the flag");

    // The overflow that was not picked must leave the flag alone
    a_flag_only_sel: assert property (conv && !irq_status_q[IRQ_TIMER_BIT] &&
        !(conv_ctrl_q[CONV_OVF_SEL_BIT] ? meas_ovf : ref_ovf) |=> !irq_status_q[IRQ_TIMER_BIT])
        else $error("unselected overflow set the flag");

    a_stop_both: assert property (conv_stop |=> stop_hold)
        else $error("counters kept running after overflow");

    a_timer_sel_void: assert property (!conv && ref_ovf |=> irq_status_q[IRQ_TIMER_BIT])
        else $error("timer overflow ignored");

    // Timer function never clears run by itself
    a_timer_run_kept: assert property (!conv && run &&
        !(wr && idx == IDX_TIMER_CTRL) |=> run) else $error("timer function cleared run");

    a_meas_idle: assert property (!conv && !meas_load |=> $stable(meas_count))
        else $error("measurement counted outside converter");

    a_hold_stopped: assert property (!run && !ref_load |=> $stable(ref_count))
        else $error("reference counted while stopped");

    // System clock mode must advance the reference on every cycle
    a_ref_step: assert property (run && ref_mode == REF_SYS && !ref_ovf |=>
        ref_count == $past(ref_count) + 16'h0001) else $error("reference missed a clock");

    a_low_write: assert property (wr && !run && idx == IDX_REF_LOW |=>
        ref_buf_q == $past(wb_dat_i[7:0]) && $stable(ref_count))
        else $error("low write did not stay in buffer");

    a_high_latch: assert property (rd && !run && idx == IDX_MEAS_HIGH |=>
        meas_buf_q == $past(meas_count[7:0])) else $error("high read did not latch low");

    a_locked_quiet: assert property (wr && locked |=>
        $stable(ref_buf_q) && $stable(meas_buf_q))
        else $error("counter register written while running");

    // Read data was captured while the request stood, so look one cycle back
    a_locked_read: assert property (wb_ack_o && $past(locked) |->
        wb_dat_o == 32'h0000_0000) else $error("locked counter register read nonzero");

    a_reserved_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000 &&
        (!$past(idx == IDX_CONV_CTRL) || wb_dat_o[3:2] == 2'h0))
        else $error("reserved bits read nonzero");

    a_div4_spacing: assert property (div_q == DIV_LAST |=> div_gap)
        else $error("instruction clock spacing wrong");

    a_switch_off: assert property (!conv |=> ref_switch_en == 3'h0 &&
        meas_switch_en == 10'h000) else $error("switches driven in timer function");

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");

    a_ack_timing: assert property (req && !wb_ack_o |=> ack_then_idle)
        else $error("acknowledge not one cycle after request");
endmodule

// ==== tb/rc_osc_model.sv ====
// Purpose: Far-side sensor network: RC oscillators and external clock sources.
// Assumes: Each source runs freely and is unrelated in phase to clk.
// Notes: Bit 0 ext a, bit 1 osc a, bit 2 osc b, bit 3 ext b.
`timescale 1ns/1ps
module rc_osc_model (
    input wire logic [3:0] run,
    input wire logic [31:0] half_ns,
    output logic [3:0] wave
);
    // A stopped network falls low at its next half period, then sits low
    initial begin
        wave = 4'h0;
        forever begin
            #(half_ns > 0 ? half_ns : 10);
            wave = ~wave & run;
        end
    end
endmodule

// ==== tb/rc_adc_dual_counter_test.sv ====
// Purpose: Self-checking bench for the dual-counter converter block.
// Assumes: Classic Wishbone cycles with one idle cycle between them.
// Notes: Count checks allow a few cycles of bus overhead.
`timescale 1ns/1ps
module rc_adc_dual_counter_test;
    import rc_adc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic rtc = 1'b0;
    logic [3:0] osc_run = 4'h0;
    int half_ns = 10;
    logic [3:0] wave;
    logic [2:0] ref_sw;
    logic [9:0] meas_sw;
    logic irq;
    int failures = 0;
    int check_count = 0;
    logic [7:0] q;
    logic [15:0] v;
    // Expected switch sets per measurement mode, last entry an undefined mode
    logic [9:0] meas_tab [9] = '{10'h100, 10'h109, 10'h111, 10'h105, 10'h10a,
                                 10'h260, 10'h2a0, 10'h200, 10'h000};

    rc_adc_dual_counter u_rc_adc_dual_counter (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rtc_tick(rtc), .ext_clock_in_a(wave[0]),
        .ext_clock_in_b(wave[3]), .osc_a_in(wave[1]), .osc_b_in(wave[2]),
        .ref_switch_en(ref_sw), .meas_switch_en(meas_sw), .irq(irq)
    );
    rc_osc_model u_rc_osc_model (.run(osc_run), .half_ns(half_ns), .wave(wave));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int id);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t item %0d got %h exp %h", $time, id, got, exp);
        end
    endtask

    // Entered just after a rising edge; returns one edge after the release
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (n >= 20) chk(16'h0, 16'h1, 999);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk({8'h0, q}, {8'h0, exp}, idx);
    endtask

    // High byte first so the low byte comes from the latched buffer
    task automatic rd16(input logic [5:0] hi);
        bus(1'b0, hi, 8'h00);
        v[15:8] = q;
        bus(1'b0, hi - 6'h1, 8'h00);
        v[7:0] = q;
    endtask

    task automatic ld16(input logic [5:0] hi, input logic [15:0] val);
        bus(1'b1, hi - 6'h1, val[7:0]);
        bus(1'b1, hi, val[15:8]);
    endtask

    task automatic run_to_stop();
        int n;
        n = 0;
        bus(1'b1, IDX_TIMER_CTRL, 8'h10);
        do begin
            bus(1'b0, IDX_TIMER_CTRL, 8'h00);
            n++;
        end while (q[4] !== 1'b0 && n < 400);
        chk({15'h0, q[4]}, 16'h0, 500);
    endtask

    task automatic t_regs();
        rd(IDX_CONV_CTRL, 8'h00);
        rd(IDX_IRQ_MASK, 8'h00);
        bus(1'b1, IDX_CONV_CTRL, 8'hff);
        rd(IDX_CONV_CTRL, 8'hf3);
        bus(1'b1, 6'h3f, 8'h5a);
        rd(6'h3f, 8'h00);
        for (int m = 0; m < 9; m++) begin
            bus(1'b1, IDX_CONV_CTRL, {4'(m), 4'h2});
            repeat (2) @(posedge clk);
            chk({6'h0, meas_sw}, {6'h0, meas_tab[m]}, m);
        end
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, IDX_TIMER_CTRL, {3'(r), 5'h0});
            repeat (2) @(posedge clk);
            chk({13'h0, ref_sw}, (r < 3) ? 16'(1 << r) : 16'h0, r);
        end
        bus(1'b1, IDX_CONV_CTRL, 8'h10);
        repeat (2) @(posedge clk);
        chk({3'h0, ref_sw, meas_sw}, 16'h0, 20);
        $display("test regs done");
    endtask

    task automatic t_buf();
        logic [5:0] hi;
        bus(1'b1, IDX_CONV_CTRL, 8'h02);
        for (int k = 0; k < 2; k++) begin
            hi = k ? IDX_MEAS_HIGH : IDX_REF_HIGH;
            bus(1'b1, hi - 6'h1, 8'h34);
            rd(hi, 8'h00);
            rd(hi - 6'h1, 8'h00);
            ld16(hi, 16'h1234);
            rd16(hi);
            chk(v, 16'h1234, 30 + k);
        end
        $display("test buffer done");
    endtask

    task automatic t_rate();
        int lo [3] = '{40, 9, 10};
        int up [3] = '{46, 12, 10};
        for (int r = 0; r < 3; r++) begin
            ld16(IDX_REF_HIGH, 16'h0000);
            bus(1'b1, IDX_TIMER_CTRL, {3'(r), 5'h10});
            repeat (10) begin
                rtc <= 1'b1;
                @(posedge clk);
                rtc <= 1'b0;
                repeat (3) @(posedge clk);
            end
            bus(1'b1, IDX_TIMER_CTRL, 8'h00);
            rd16(IDX_REF_HIGH);
            chk(16'(v >= lo[r] && v <= up[r]), 16'h1, 40 + r);
        end
        $display("test rate done");
    endtask

    task automatic t_ovf_ref();
        ld16(IDX_REF_HIGH, 16'hff00);
        ld16(IDX_MEAS_HIGH, 16'h0000);
        bus(1'b1, IDX_CONV_CTRL, 8'h02);
        osc_run <= 4'h1;
        bus(1'b1, IDX_TIMER_CTRL, 8'h10);
        rd(IDX_REF_HIGH, 8'h00);
        run_to_stop();
        osc_run <= 4'h0;
        rd(IDX_IRQ_STATUS, 8'h10);
        chk({15'h0, irq}, 16'h0, 50);
        rd16(IDX_REF_HIGH);
        chk(v, 16'h0000, 51);
        rd16(IDX_MEAS_HIGH);
        chk(16'(v >= 50 && v <= 80), 16'h1, 52);
        bus(1'b1, IDX_IRQ_MASK, 8'h10);
        chk({15'h0, irq}, 16'h1, 53);
        bus(1'b1, IDX_IRQ_STATUS, 8'h10);
        rd(IDX_IRQ_STATUS, 8'h00);
        chk({15'h0, irq}, 16'h0, 54);
        $display("test ref overflow done");
    endtask

    task automatic t_ovf_meas();
        ld16(IDX_REF_HIGH, 16'hff00);
        ld16(IDX_MEAS_HIGH, 16'h0000);
        bus(1'b1, IDX_CONV_CTRL, 8'h13);
        run_to_stop();
        rd(IDX_IRQ_STATUS, 8'h00);
        ld16(IDX_REF_HIGH, 16'h0000);
        ld16(IDX_MEAS_HIGH, 16'hfff0);
        half_ns = 40;
        osc_run <= 4'h2;
        run_to_stop();
        osc_run <= 4'h0;
        rd(IDX_IRQ_STATUS, 8'h10);
        chk({15'h0, irq}, 16'h1, 60);
        rd16(IDX_MEAS_HIGH);
        chk(v, 16'h0000, 61);
        rd16(IDX_REF_HIGH);
        chk(16'(v >= 230 && v <= 300), 16'h1, 62);
        bus(1'b1, IDX_IRQ_STATUS, 8'h10);
        chk({15'h0, irq}, 16'h0, 63);
        $display("test meas overflow done");
    endtask

    // Timer function: select bit void, run kept, reload from the measurement word
    task automatic t_timer();
        bus(1'b1, IDX_CONV_CTRL, 8'h01);
        ld16(IDX_MEAS_HIGH, 16'h1200);
        ld16(IDX_REF_HIGH, 16'hfff8);
        osc_run <= 4'h1;
        bus(1'b1, IDX_TIMER_CTRL, 8'h10);
        repeat (20) @(posedge clk);
        rd(IDX_TIMER_CTRL, 8'h10);
        bus(1'b1, IDX_TIMER_CTRL, 8'h00);
        osc_run <= 4'h0;
        rd(IDX_IRQ_STATUS, 8'h10);
        chk({15'h0, irq}, 16'h1, 70);
        rd16(IDX_REF_HIGH);
        chk(16'(v > 16'h1200 && v < 16'h1240), 16'h1, 71);
        rd16(IDX_MEAS_HIGH);
        chk(v, 16'h1200, 72);
        $display("test timer function done");
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, far beyond the thousand-odd cycles the tests need
    initial begin
        #200000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_buf();
        t_rate();
        t_ovf_ref();
        t_ovf_meas();
        t_timer();
        end_sim();
    end
endmodule
